// File: rtl/msx_core.sv
// executor for a small subset of an 8-bit controller's instructions
// assumes an apb master on pclk; instructions are issued by apb writes
//
// Notes on behaviour
// - watchdog clear zeroes the watchdog counter
// - also zeroes divider when assigned to watchdog
// - watchdog clear sets timeout and powerdown flags
// - compare sets zero, carry from file minus working
// - compare leaves working and file register untouched
// - decimal adjust: working register to packed bcd
// - count down skip writes per destination bit
// - zero result discards next instruction as nop
// - skip instruction costs one or two cycles
// - count down writes per destination, updates zero
// - interrupt mask all clears global enable
`timescale 1ns/1ps
`default_nettype none
module msx_core #(
  parameter int FILE_AW = 7,
  parameter int WDT_W = 8,
  parameter int DIV_W = 8,
  parameter int CYC_W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic global_irq_enable,
  output logic timeout_flag_n,
  output logic powerdown_flag_n
);
  msx_pkg::msx_state_t state;
  msx_pkg::msx_op_t ins_op;
  logic ins_dst;
  logic [FILE_AW-1:0] ins_addr;
  logic [7:0] working_register;
  logic carry;
  logic half_carry;
  logic zero;
  logic psa_wdt;
  logic skip_pending;
  logic rd_wait;
  logic [WDT_W-1:0] wdt_count;
  logic [DIV_W-1:0] shared_divider;
  logic [CYC_W-1:0] cycles;
  logic [7:0] mem_rdata;
  logic [7:0] mem_wdata;
  logic [FILE_AW-1:0] mem_addr;
  logic mem_we;
  logic access_phase;
  logic idle;
  logic hit_file;
  logic mapped;
  logic wr_fire;
  logic ins_fire;
  logic exec;
  logic [31:0] rd_value;
  logic [7:0] down_res;
  logic [8:0] cmp_diff;
  logic [8:0] bcd_s1;
  logic [8:0] bcd_s2;
  logic bcd_lo;
  logic bcd_hi;
  logic wdt_tick;
  logic wdt_ovf;
  logic down_dest_file;

  // access decode
  assign access_phase = psel & penable;
  assign idle = (state == msx_pkg::ST_IDLE);
  assign exec = (state == msx_pkg::ST_EXEC);
  assign hit_file = (paddr[11:msx_pkg::FILE_SEL_LSB] == msx_pkg::FILE_SEL) &&
    (paddr[msx_pkg::FILE_IDX_LSB-1:0] == '0); // unaligned file words answer with error
  assign wr_fire = access_phase & pready & pwrite;
  assign ins_fire = wr_fire & (paddr == msx_pkg::OFF_INSTR);

  // which addresses answer without error
  always_comb begin
    mapped = hit_file;
    case (paddr)
      msx_pkg::OFF_INSTR: mapped = 1'b1;
      msx_pkg::OFF_WORK: mapped = 1'b1;
      msx_pkg::OFF_STATUS: mapped = 1'b1;
      msx_pkg::OFF_WDT: mapped = 1'b1;
      msx_pkg::OFF_DIV: mapped = 1'b1;
      msx_pkg::OFF_CYCLES: mapped = 1'b1;
      default: mapped = hit_file;
    endcase
  end

  // read data mux
  always_comb begin
    rd_value = 32'h0;
    if (hit_file) begin
      rd_value[7:0] = mem_rdata;
    end else begin
      case (paddr)
        msx_pkg::OFF_INSTR: begin
          rd_value[msx_pkg::INS_BUSY_BIT] = ~idle;
          rd_value[msx_pkg::INS_SKIP_BIT] = skip_pending;
        end
        msx_pkg::OFF_WORK: rd_value[7:0] = working_register;
        msx_pkg::OFF_STATUS: begin
          rd_value[msx_pkg::ST_C] = carry;
          rd_value[msx_pkg::ST_DC] = half_carry;
          rd_value[msx_pkg::ST_Z] = zero;
          rd_value[msx_pkg::ST_PWRDN] = powerdown_flag_n;
          rd_value[msx_pkg::ST_TMOUT] = timeout_flag_n;
          rd_value[msx_pkg::ST_IRQ_EN] = global_irq_enable;
          rd_value[msx_pkg::ST_PSA] = psa_wdt;
        end
        msx_pkg::OFF_WDT: rd_value[WDT_W-1:0] = wdt_count;
        msx_pkg::OFF_DIV: rd_value[DIV_W-1:0] = shared_divider;
        msx_pkg::OFF_CYCLES: rd_value[CYC_W-1:0] = cycles;
        default: rd_value = 32'h0;
      endcase
    end
  end

  // apb answer: one wait state, two for file reads, no answer while busy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
      rd_wait <= 1'b0;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      if (access_phase && !pready && idle) begin
        if (hit_file && !pwrite && !rd_wait) begin
          rd_wait <= 1'b1; // let the ram register the word
        end else begin
          rd_wait <= 1'b0;
          pready <= 1'b1;
          pslverr <= ~mapped;
          prdata <= pwrite ? 32'h0 : rd_value;
        end
      end
    end
  end

  // single ram port shared by software and execution
  always_comb begin
    if (idle) begin
      mem_addr = paddr[msx_pkg::FILE_IDX_LSB +: FILE_AW];
      mem_we = wr_fire & hit_file;
      mem_wdata = pwdata[7:0];
    end else begin
      mem_addr = ins_addr;
      mem_we = exec & down_dest_file;
      mem_wdata = down_res;
    end
  end

  msx_file_ram #(
    .ADDR_W(FILE_AW),
    .DATA_W(8)
  ) u_ram (
    .clk(pclk),
    .we(mem_we),
    .addr(mem_addr),
    .wdata(mem_wdata),
    .rdata(mem_rdata)
  );

  // arithmetic on the fetched operand
  assign down_res = mem_rdata - msx_pkg::BYTE_ONE;
  assign cmp_diff = {1'b0, mem_rdata} - {1'b0, working_register};
  assign down_dest_file = ins_dst &&
    ((ins_op == msx_pkg::OP_DOWN_SKIP) || (ins_op == msx_pkg::OP_DOWN));

  // decimal adjust of the working register
  assign bcd_lo = (working_register[3:0] > msx_pkg::BCD_MAX) | half_carry;
  assign bcd_s1 = {1'b0, working_register} + (bcd_lo ? msx_pkg::BCD_LO_FIX : 9'h000);
  assign bcd_hi = carry | bcd_s1[8] | (bcd_s1[7:4] > msx_pkg::BCD_MAX);
  assign bcd_s2 = bcd_s1 + (bcd_hi ? msx_pkg::BCD_HI_FIX : 9'h000);

  // instruction sequencer: fetch operand, then execute
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= msx_pkg::ST_IDLE;
      ins_op <= msx_pkg::OP_NOP;
      ins_dst <= 1'b0;
      ins_addr <= '0;
    end else begin
      case (state)
        msx_pkg::ST_IDLE: begin
          if (ins_fire && !skip_pending) begin
            ins_op <= msx_pkg::msx_op_t'(pwdata[msx_pkg::INS_OP_LSB +: 3]);
            ins_dst <= pwdata[msx_pkg::INS_DST_BIT];
            ins_addr <= pwdata[msx_pkg::INS_ADDR_LSB +: FILE_AW];
            state <= msx_pkg::ST_FETCH;
          end
        end
        msx_pkg::ST_FETCH: state <= msx_pkg::ST_EXEC;
        msx_pkg::ST_EXEC: state <= msx_pkg::ST_IDLE;
        default: state <= msx_pkg::ST_IDLE;
      endcase
    end
  end

  // skip handling: a zero count down skip drops the next issued word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      skip_pending <= 1'b0;
    end else if (ins_fire && skip_pending) begin
      skip_pending <= 1'b0; // fetched word dropped, nop runs
    end else if (exec && ins_op == msx_pkg::OP_DOWN_SKIP &&
        down_res == msx_pkg::BYTE_ZERO) begin
      skip_pending <= 1'b1;
    end
  end

  // instruction cycle count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cycles <= '0;
    end else if (ins_fire && skip_pending) begin
      cycles <= cycles + 1'b1; // second cycle of the skip
    end else if (exec) begin
      cycles <= cycles + 1'b1; // one cycle per executed word
    end
  end

  // working register: software write, decimal adjust result, or count down result with destination 0
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      working_register <= 8'h00;
    end else if (wr_fire && paddr == msx_pkg::OFF_WORK) begin
      working_register <= pwdata[7:0];
    end else if (exec) begin
      case (ins_op)
        msx_pkg::OP_DEC_ADJ: working_register <= bcd_s2[7:0];
        msx_pkg::OP_DOWN_SKIP,
        msx_pkg::OP_DOWN: begin
          if (!ins_dst) begin
            working_register <= down_res;
          end
        end
        default: working_register <= working_register;
      endcase
    end
  end

  // arithmetic flags: software write or compare, adjust and count down (not skip) results
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      carry <= 1'b0;
      half_carry <= 1'b0;
      zero <= 1'b0;
    end else if (wr_fire && paddr == msx_pkg::OFF_STATUS) begin
      carry <= pwdata[msx_pkg::ST_C];
      half_carry <= pwdata[msx_pkg::ST_DC];
      zero <= pwdata[msx_pkg::ST_Z];
    end else if (exec) begin
      case (ins_op)
        msx_pkg::OP_COMPARE: begin
          carry <= ~cmp_diff[8]; // no borrow gives one
          zero <= (cmp_diff[7:0] == msx_pkg::BYTE_ZERO);
        end
        msx_pkg::OP_DEC_ADJ: carry <= bcd_hi; // only carry moves
        msx_pkg::OP_DOWN: zero <= (down_res == msx_pkg::BYTE_ZERO);
        default: zero <= zero; // skip count down leaves the flags alone
      endcase
    end
  end

  // divider assignment: software only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      psa_wdt <= msx_pkg::PSA_RESET;
    end else if (wr_fire && paddr == msx_pkg::OFF_STATUS) begin
      psa_wdt <= pwdata[msx_pkg::ST_PSA];
    end
  end

  // global interrupt enable: software write or the mask all instruction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      global_irq_enable <= msx_pkg::IRQ_EN_RESET;
    end else if (wr_fire && paddr == msx_pkg::OFF_STATUS) begin
      global_irq_enable <= pwdata[msx_pkg::ST_IRQ_EN];
    end else if (exec && ins_op == msx_pkg::OP_IRQ_OFF) begin
      global_irq_enable <= 1'b0;
    end
  end

  // timeout and powerdown flags; watchdog timeout wins over a same-cycle clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timeout_flag_n <= msx_pkg::FLAG_N_RESET;
      powerdown_flag_n <= msx_pkg::FLAG_N_RESET;
    end else begin
      if (wr_fire && paddr == msx_pkg::OFF_STATUS) begin
        timeout_flag_n <= pwdata[msx_pkg::ST_TMOUT];
        powerdown_flag_n <= pwdata[msx_pkg::ST_PWRDN];
      end
      if (exec && ins_op == msx_pkg::OP_WDT_CLEAR) begin
        timeout_flag_n <= 1'b1;
        powerdown_flag_n <= 1'b1;
      end
      if (wdt_ovf) begin
        timeout_flag_n <= 1'b0;
      end
    end
  end

  // watchdog counter and the shared divider
  assign wdt_tick = psa_wdt ? (&shared_divider) : 1'b1;
  assign wdt_ovf = wdt_tick & (&wdt_count);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdt_count <= '0;
      shared_divider <= '0;
    end else if (exec && ins_op == msx_pkg::OP_WDT_CLEAR) begin
      wdt_count <= '0;
      if (psa_wdt) begin
        shared_divider <= '0;
      end else begin
        shared_divider <= shared_divider + 1'b1;
      end
    end else begin
      shared_divider <= shared_divider + 1'b1;
      if (wdt_tick) begin
        wdt_count <= wdt_count + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// File: rtl/msx_file_ram.sv
// file register array: one data page of byte locations
// assumes a single port; read data are registered, write is synchronous
`timescale 1ns/1ps
`default_nettype none
module msx_file_ram #(
  parameter int ADDR_W = 7,
  parameter int DATA_W = 8
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  output logic [DATA_W-1:0] rdata
);
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

  // read first: the old word goes out through a register while the write lands
  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule
`default_nettype wire

// File: rtl/msx_pkg.sv
// constants and types shared by the instruction subset executor
// assumes an apb master with a 12-bit byte address and 32-bit data
package msx_pkg;
  // register byte offsets
  localparam logic [11:0] OFF_INSTR = 12'h000;
  localparam logic [11:0] OFF_WORK = 12'h004;
  localparam logic [11:0] OFF_STATUS = 12'h008;
  localparam logic [11:0] OFF_WDT = 12'h00c;
  localparam logic [11:0] OFF_DIV = 12'h010;
  localparam logic [11:0] OFF_CYCLES = 12'h014;
  // file registers sit at 0x200 + 4 * index
  localparam logic [2:0] FILE_SEL = 3'h1;
  localparam int FILE_SEL_LSB = 9;
  localparam int FILE_IDX_LSB = 2;
  // instruction word fields
  localparam int INS_ADDR_LSB = 0;
  localparam int INS_DST_BIT = 7;
  localparam int INS_OP_LSB = 8;
  localparam int INS_BUSY_BIT = 0;
  localparam int INS_SKIP_BIT = 1;
  // status word fields
  localparam int ST_C = 0;
  localparam int ST_DC = 1;
  localparam int ST_Z = 2;
  localparam int ST_PWRDN = 3;
  localparam int ST_TMOUT = 4;
  localparam int ST_IRQ_EN = 5;
  localparam int ST_PSA = 6;
  // reset values
  localparam logic FLAG_N_RESET = 1'h1;
  localparam logic IRQ_EN_RESET = 1'h0;
  localparam logic PSA_RESET = 1'h1;
  // decimal adjust and byte constants
  localparam logic [3:0] BCD_MAX = 4'h9;
  localparam logic [8:0] BCD_LO_FIX = 9'h006;
  localparam logic [8:0] BCD_HI_FIX = 9'h060;
  localparam logic [7:0] BYTE_ONE = 8'h01;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  typedef enum logic [2:0] {
    OP_NOP = 3'b000,
    OP_WDT_CLEAR = 3'b001,
    OP_COMPARE = 3'b010,
    OP_DEC_ADJ = 3'b011,
    OP_DOWN_SKIP = 3'b100,
    OP_DOWN = 3'b101,
    OP_IRQ_OFF = 3'b110
  } msx_op_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FETCH = 2'b01,
    ST_EXEC = 2'b10
  } msx_state_t;
endpackage

// File: verification/msx_core_asserts.sv
// checker for msx_core: apb answers and status outputs
// assumes it is bound to every msx_core instance
`timescale 1ns/1ps
`default_nettype none
module msx_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic global_irq_enable,
  input wire logic timeout_flag_n,
  input wire logic powerdown_flag_n
);
  logic [2:0] since_wr;
  logic ctl_wr;
  logic mapped;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence acc_done;
    psel && penable && pready;
  endsequence
  // decode of accepted instruction and status writes and of the register map
  assign ctl_wr = psel && penable && pready && pwrite && (paddr == 12'h000 || paddr == 12'h008);
  assign mapped = paddr[1:0] == 2'h0 && (paddr <= 12'h014 || paddr[11:9] == 3'h1);
  // cycles since the last instruction or status write, saturating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      since_wr <= 3'h7;
    end else if (ctl_wr) begin
      since_wr <= 3'h0;
    end else if (since_wr != 3'h7) begin
      since_wr <= since_wr + 3'h1;
    end
  end
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
  a_ready_in_access: assert property (pready |-> acc_done) else $error("pready outside access");
  a_err_with_ready: assert property (pslverr |-> acc_done) else $error("stray pslverr");
  a_map_no_err: assert property (acc_done and mapped |-> !pslverr) else $error("bad pslverr");
  a_unmapped_err: assert property (acc_done and !mapped |-> pslverr) else $error("no pslverr");
  a_err_reads_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("error read not zero");
  a_irq_en_cause: assert property (!$stable(global_irq_enable) |-> since_wr < 3'h6)
    else $error("global enable moved without cause");
  a_to_rise_cause: assert property ($rose(timeout_flag_n) |-> since_wr < 3'h6)
    else $error("timeout flag rose without cause");
  a_pd_cause: assert property (!$stable(powerdown_flag_n) |-> since_wr < 3'h6)
    else $error("powerdown flag moved without cause");
endmodule
bind msx_core msx_asserts chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .global_irq_enable(global_irq_enable),
  .timeout_flag_n(timeout_flag_n), .powerdown_flag_n(powerdown_flag_n));
`default_nettype wire

// File: verification/tb_top.sv
// self-checking bench for msx_core driven over apb
// assumes the rtl package and core are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, irq_en, tmout_n, pwrdn_n, err;
  logic [31:0] rd, c0;
  logic [7:0] cf[3] = '{8'h34, 8'h12, 8'h55};
  logic [7:0] cw[3] = '{8'h12, 8'h34, 8'h55};
  logic [7:0] cs[3] = '{8'h01, 8'h00, 8'h05};
  int miscompares = 0;
  int checked = 0;
  // 10 mhz clock
  always #50 pclk = ~pclk;
  msx_core dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .global_irq_enable(irq_en), .timeout_flag_n(tmout_n),
    .powerdown_flag_n(pwrdn_n));
  task automatic stop_test();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer, entered just after a rising edge
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rd & m, e);
  endtask
  task automatic exe(input logic [2:0] op, input logic dst, input logic [6:0] f);
    xfer(1'b1, 12'h000, {21'h0, op, dst, f});
    // let fetch and execute finish so results are settled on return
    repeat (2) @(posedge pclk);
  endtask
  function automatic logic [11:0] fa(input logic [6:0] i);
    return {3'h1, i, 2'h0};
  endfunction
  // watchdog against a hung handshake
  initial begin
    repeat (5000) @(posedge pclk);
    miscompares++;
    stop_test();
  end
  // main sequence
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rc(12'h008, 32'hff, 32'h58);
    xfer(1'b1, 12'h008, 32'h60);
    chk({irq_en, tmout_n, pwrdn_n}, 32'h4);
    exe(3'h1, 1'b0, 7'h00);
    rc(12'h00c, 32'hff, 32'h0);
    rc(12'h010, 32'hf0, 32'h0);
    chk({tmout_n, pwrdn_n}, 32'h3);
    exe(3'h6, 1'b0, 7'h00);
    chk(irq_en, 32'h0);
    for (int i = 0; i < 3; i++) begin
      xfer(1'b1, fa(7'h09), cf[i]);
      xfer(1'b1, 12'h004, cw[i]);
      xfer(1'b1, 12'h008, 32'h40);
      exe(3'h2, 1'b1, 7'h09);
      rc(12'h008, 32'h5, cs[i]);
      rc(12'h004, 32'hff, cw[i]);
      rc(fa(7'h09), 32'hff, cf[i]);
    end
    xfer(1'b1, 12'h008, 32'h40); // carry clear, interrupts masked
    xfer(1'b1, 12'h004, 32'h4d);
    exe(3'h3, 1'b0, 7'h00); // adjust right after the sum
    rc(12'h004, 32'hff, 32'h53);
    xfer(1'b1, 12'h004, 32'h9a);
    xfer(1'b1, 12'h008, 32'h44); // interrupts stay masked
    exe(3'h3, 1'b0, 7'h00);
    rc(12'h004, 32'hff, 32'h0);
    rc(12'h008, 32'h5, 32'h5);
    xfer(1'b1, 12'h008, 32'h40);
    xfer(1'b1, fa(7'h05), 32'h1);
    exe(3'h5, 1'b0, 7'h05);
    rc(12'h004, 32'hff, 32'h0);
    rc(12'h008, 32'h4, 32'h4);
    xfer(1'b1, fa(7'h7f), 32'h80);
    exe(3'h5, 1'b1, 7'h7f);
    rc(fa(7'h7f), 32'hff, 32'h7f);
    rc(12'h008, 32'h4, 32'h0);
    xfer(1'b1, fa(7'h03), 32'h2);
    xfer(1'b1, 12'h008, 32'h60);
    xfer(1'b0, 12'h014, 32'h0);
    c0 = rd;
    exe(3'h4, 1'b1, 7'h03);
    rc(fa(7'h03), 32'hff, 32'h1);
    rc(12'h000, 32'h3, 32'h0);
    rc(12'h014, 32'hffff, (c0 + 32'h1) & 32'hffff);
    exe(3'h4, 1'b0, 7'h03);
    rc(12'h004, 32'hff, 32'h0);
    rc(12'h000, 32'h3, 32'h2);
    exe(3'h6, 1'b0, 7'h00);
    chk(irq_en, 32'h1);
    rc(12'h014, 32'hffff, (c0 + 32'h3) & 32'hffff);
    rc(fa(7'h03), 32'hff, 32'h1);
    // divider given to the timer: clear must leave it counting
    xfer(1'b1, 12'h008, 32'h00);
    xfer(1'b0, 12'h010, 32'h0);
    c0 = rd;
    exe(3'h1, 1'b0, 7'h00);
    rc(12'h010, 32'hff, (c0 + 32'ha) & 32'hff);
    chk({tmout_n, pwrdn_n}, 32'h3);
    rc(12'h400, 32'hffffffff, 32'h0);
    chk(err, 32'h1);
    rc(12'h018, 32'hffffffff, 32'h0);
    chk(err, 32'h1);
    stop_test();
  end
endmodule
`default_nettype wire
